// [hw/rsi_device.sv]
`timescale 1ns/1ps
// Function
// (R1) sda fall while scl high starts transfer
// (R2) sda rise while scl high ends transfer
// (R3) sda changes only while scl low
// (R4) one bit per scl pulse, sampled high
// (R5) master starts only on idle bus
// (R6) receiver acks each byte on ninth pulse
// (R7) ack holds sda low through scl high
// (R8) master nacks last read byte, slave releases
// (R9) control byte: code plus direction bit
// (R10) code 1101111 selects clock and sram
// (R11) code 1010111 selects unlocked id space
// (R12) ack matching code, then read or write
// (R13) word address follows, msb first
// (R14) no id ack while id programming
// (R15) stop after id write starts cycle
// (R16) master polls with write control byte
// (R17) registers 0x00-0x1f, sram 0x20-0x5f
// (R18) nack out-of-range word address
// (R19) unimplemented locations read zero
// (R20) time writes accepted without checks
// (R21) decode address into register regions
// (R22) master writes time before seconds rollover
// (R23) sda only pulled low or released
// (R24) synchronise scl and sda before detection
module rsi_device
    import rsi_pkg::*;
#(
    parameter int WC_CYCLES = RSI_ID_WC_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    rsi_if.slave bus,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output rsi_region_t wr_region,
    output logic id_busy
);
    typedef enum logic [2:0] {DS_IDLE, DS_CTRL, DS_ADDR, DS_WDATA, DS_RDATA} rsi_dst_t;
    localparam int WCW = $clog2(WC_CYCLES + 1);

    logic [1:0] lrst_q;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    rsi_dst_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic idsp_q;
    logic rd_q;
    logic oe_n_q;
    logic mack_q;
    logic idwr_q;
    logic stage_q;
    logic unl_q;
    logic [WCW-1:0] wc_q;
    logic busy_l_q;
    logic [7:0] mem_q [RSI_MEM_BYTES];
    logic [7:0] id_q [RSI_ID_BYTES];
    logic ev_tgl_q;
    logic [7:0] ev_addr_q;
    logic [7:0] ev_data_q;
    rsi_region_t ev_rg_q;
    logic [2:0] tgl_q;
    logic [1:0] busy_q;
    logic wr_pulse_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    rsi_region_t wr_region_q;

    wire lrst = lrst_q[1];
    wire scl_h = scl_q[1] & scl_q[2];
    wire start_w = scl_h & sda_q[2] & ~sda_q[1]; // R1
    wire stop_w = scl_h & ~sda_q[2] & sda_q[1]; // R2
    wire rise_w = scl_q[1] & ~scl_q[2];
    wire fall_w = ~scl_q[1] & scl_q[2];
    wire busy_w = wc_q != '0;
    wire [6:0] code_w = sh_q[7:1];
    wire hit_rtc = code_w == RSI_CODE_RTC; // R10
    wire hit_id = (code_w == RSI_CODE_ID) & ~busy_w; // R11 R14
    wire addr_ok = idsp_q ? (sh_q < RSI_ID_BYTES) : (sh_q <= RSI_SRAM_LAST); // R17 R18
    wire in_rng = idsp_q ? (ptr_q < RSI_ID_BYTES) : (ptr_q <= RSI_SRAM_LAST);
    wire [7:0] rd_w = !in_rng ? RSI_ZERO_RST :
                      idsp_q ? id_q[ptr_q[2:0]] : mem_q[ptr_q[6:0]]; // R19
    wire byte_end = fall_w & (bit_q == 4'd7);
    wire ack_w = (st_q == DS_CTRL) ? (hit_rtc | hit_id) : // R12
                 (st_q == DS_ADDR) ? addr_ok :
                 (st_q == DS_WDATA); // R6
    wire wr_w = byte_end & (st_q == DS_WDATA) & in_rng;
    wire mem_we = wr_w & ~idsp_q; // R20
    wire id_we = wr_w & idsp_q & unl_q; // R11
    wire rsi_region_t rg_w = idsp_q ? RSI_RG_ID :
                             (ptr_q <= RSI_TIME_LAST) ? RSI_RG_TIME :
                             (ptr_q <= RSI_CFG_LAST) ? RSI_RG_CFG :
                             (ptr_q <= RSI_ALM0_LAST) ? RSI_RG_ALM0 :
                             (ptr_q <= RSI_ALM1_LAST) ? RSI_RG_ALM1 :
                             (ptr_q <= RSI_RTC_LAST) ? RSI_RG_TSTAMP : RSI_RG_SRAM; // R21

    // reset and line synchronisers into the link domain
    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[0], rst};
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], bus.scl}; // R24
            sda_q <= {sda_q[1:0], bus.sda}; // R24
        end
    end

    // bit sampling on scl high
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            sh_q <= 8'h00;
            mack_q <= 1'b0;
        end else if (rise_w && bit_q < 4'd8) begin
            sh_q <= {sh_q[6:0], sda_q[1]}; // R4 R9 R13
        end else if (rise_w && bit_q == 4'd8) begin
            mack_q <= ~sda_q[1]; // R8
        end
    end

    // transfer sequencer; drive changes only after scl falls
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            st_q <= DS_IDLE;
            bit_q <= 4'h0;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            idsp_q <= 1'b0;
            rd_q <= 1'b0;
            oe_n_q <= 1'b1;
            idwr_q <= 1'b0;
        end else if (start_w) begin
            st_q <= DS_CTRL;
            bit_q <= 4'hf;
            oe_n_q <= 1'b1;
        end else if (stop_w) begin
            st_q <= DS_IDLE;
            oe_n_q <= 1'b1;
            idwr_q <= 1'b0;
        end else if (st_q != DS_IDLE && fall_w) begin // R3
            if (bit_q == 4'd7) begin
                bit_q <= 4'd8;
                oe_n_q <= ~ack_w; // R7 R23
                unique case (st_q)
                    DS_CTRL: begin
                        idsp_q <= hit_id;
                        rd_q <= sh_q[0]; // R9
                        if (!ack_w) begin
                            st_q <= DS_IDLE;
                        end
                    end
                    DS_ADDR: begin
                        ptr_q <= sh_q; // R13
                        if (!ack_w) begin
                            st_q <= DS_IDLE; // R18
                        end
                    end
                    DS_WDATA: begin
                        ptr_q <= ptr_q + 8'h01;
                        idwr_q <= idwr_q | id_we;
                    end
                    DS_RDATA: begin
                        ptr_q <= ptr_q + 8'h01;
                    end
                    DS_IDLE: begin
                    end
                endcase
            end else if (bit_q == 4'd8) begin
                bit_q <= 4'h0;
                oe_n_q <= 1'b1;
                if (st_q == DS_CTRL && rd_q) begin
                    st_q <= DS_RDATA; // R12
                    tx_q <= rd_w;
                    oe_n_q <= rd_w[7]; // R23
                end else if (st_q == DS_CTRL) begin
                    st_q <= DS_ADDR; // R12
                end else if (st_q == DS_ADDR) begin
                    st_q <= DS_WDATA;
                end else if (st_q == DS_RDATA && mack_q) begin
                    tx_q <= rd_w;
                    oe_n_q <= rd_w[7];
                end else if (st_q == DS_RDATA) begin
                    st_q <= DS_IDLE; // R8
                end
            end else begin
                bit_q <= 4'(bit_q + 4'h1);
                if (st_q == DS_RDATA) begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    oe_n_q <= tx_q[6]; // R23
                end
            end
        end
    end

    // storage
    for (genvar i = 0; i < RSI_MEM_BYTES; i++) begin : g_mem
        always_ff @(posedge link_clk) begin
            if (lrst) begin
                mem_q[i] <= rsi_reset_val(8'(i));
            end else if (mem_we && ptr_q[6:0] == 7'(i)) begin
                mem_q[i] <= sh_q; // R20
            end
        end
    end

    for (genvar i = 0; i < RSI_ID_BYTES; i++) begin : g_id
        always_ff @(posedge link_clk) begin
            if (lrst) begin
                id_q[i] <= RSI_ZERO_RST;
            end else if (id_we && ptr_q[2:0] == 3'(i)) begin
                id_q[i] <= sh_q;
            end
        end
    end

    // id unlock and internally timed programming cycle
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            stage_q <= 1'b0;
            unl_q <= 1'b0;
            wc_q <= '0;
            busy_l_q <= 1'b0;
        end else begin
            busy_l_q <= busy_w;
            if (stop_w && idwr_q) begin
                wc_q <= WCW'(WC_CYCLES); // R15
                unl_q <= 1'b0;
            end else if (busy_w) begin
                wc_q <= wc_q - 1'b1;
            end
            if (mem_we && ptr_q == RSI_UNLOCK_ADDR) begin
                stage_q <= sh_q == RSI_UNLOCK_KEY1;
                if (stage_q && sh_q == RSI_UNLOCK_KEY2) begin
                    unl_q <= 1'b1;
                end
            end
        end
    end

    // write event held for the system clock domain
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            ev_tgl_q <= 1'b0;
            ev_addr_q <= 8'h00;
            ev_data_q <= 8'h00;
            ev_rg_q <= RSI_RG_TIME;
        end else if (mem_we || id_we) begin
            ev_tgl_q <= ~ev_tgl_q;
            ev_addr_q <= ptr_q;
            ev_data_q <= sh_q;
            ev_rg_q <= rg_w;
        end
    end

    // system clock side
    always_ff @(posedge clock) begin
        if (rst) begin
            tgl_q <= 3'h0;
            busy_q <= 2'h0;
            wr_pulse_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_region_q <= RSI_RG_TIME;
        end else begin
            tgl_q <= {tgl_q[1:0], ev_tgl_q};
            busy_q <= {busy_q[0], busy_l_q};
            wr_pulse_q <= tgl_q[2] ^ tgl_q[1];
            if (tgl_q[2] ^ tgl_q[1]) begin
                wr_addr_q <= ev_addr_q;
                wr_data_q <= ev_data_q;
                wr_region_q <= ev_rg_q;
            end
        end
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = oe_n_q;
    assign wr_pulse = wr_pulse_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign wr_region = wr_region_q;
    assign id_busy = busy_q[1];
endmodule

// [pkg/rsi_pkg.sv]
package rsi_pkg;
    // control codes of the two address spaces
    localparam logic [6:0] RSI_CODE_RTC = 7'h6f;
    localparam logic [6:0] RSI_CODE_ID = 7'h57;
    // clock registers and sram in one space
    localparam int RSI_MEM_BYTES = 96;
    localparam logic [7:0] RSI_TIME_LAST = 8'h06;
    localparam logic [7:0] RSI_CFG_LAST = 8'h09;
    localparam logic [7:0] RSI_ALM0_LAST = 8'h10;
    localparam logic [7:0] RSI_ALM1_LAST = 8'h17;
    localparam logic [7:0] RSI_RTC_LAST = 8'h1f;
    localparam logic [7:0] RSI_SRAM_LAST = 8'h5f;
    // unique id space and its unlock
    localparam logic [7:0] RSI_ID_BYTES = 8'h08;
    localparam logic [7:0] RSI_UNLOCK_ADDR = 8'h09;
    localparam logic [7:0] RSI_UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] RSI_UNLOCK_KEY2 = 8'haa;
    // reset values
    localparam logic [7:0] RSI_CTRL_ADDR = 8'h07;
    localparam logic [7:0] RSI_CTRL_RST = 8'h80;
    localparam logic [7:0] RSI_DAY_ADDR = 8'h03;
    localparam logic [7:0] RSI_A0DAY_ADDR = 8'h0d;
    localparam logic [7:0] RSI_A1DAY_ADDR = 8'h14;
    localparam logic [7:0] RSI_ONE_RST = 8'h01;
    localparam logic [7:0] RSI_ZERO_RST = 8'h00;
    // timing
    localparam int RSI_CLK_MHZ = 200;
    localparam int RSI_SCL_KHZ = 400;
    localparam int RSI_SCL_QTR_CYC = (RSI_CLK_MHZ * 1000) / (RSI_SCL_KHZ * 4);
    localparam int RSI_BUS_IDLE_CYC = RSI_SCL_QTR_CYC;
    localparam int RSI_ID_WC_NS = 5000000;
    localparam int RSI_LINK_PERIOD_NS = 12;
    localparam int RSI_ID_WC_CYC = RSI_ID_WC_NS / RSI_LINK_PERIOD_NS;

    typedef enum logic [2:0] {
        RSI_RG_TIME, RSI_RG_CFG, RSI_RG_ALM0, RSI_RG_ALM1, RSI_RG_TSTAMP, RSI_RG_SRAM, RSI_RG_ID
    } rsi_region_t;

    function automatic logic [7:0] rsi_reset_val(input logic [7:0] a);
        logic [7:0] v;
        v = RSI_ZERO_RST;
        if (a == RSI_CTRL_ADDR) begin
            v = RSI_CTRL_RST;
        end else if ((a >= RSI_DAY_ADDR && a <= RSI_TIME_LAST) ||
                     (a >= RSI_A0DAY_ADDR && a <= RSI_ALM0_LAST) ||
                     (a >= RSI_A1DAY_ADDR && a <= RSI_ALM1_LAST)) begin
            v = RSI_ONE_RST;
        end
        return v;
    endfunction
endpackage

// [pkg/rsi_if.sv]
`timescale 1ns/1ps
interface rsi_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    wire scl;
    wire sda;
    // open-drain lines with pull-up
    assign scl = m_scl_oe_n ? 1'b1 : m_scl_o;
    assign sda = (m_sda_oe_n ? 1'b1 : m_sda_o) & (s_sda_oe_n ? 1'b1 : s_sda_o);
    modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n,
                    input scl, input sda);
    modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// [hw/rsi_host.sv]
`timescale 1ns/1ps
module rsi_host
    import rsi_pkg::*;
#(
    parameter int QTR_CYC = RSI_SCL_QTR_CYC,
    parameter logic [7:0] POLL_MAX = 8'hff
) (
    input wire logic clock,
    input wire logic rst,
    rsi_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_id,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic time_wr_hold,
    output logic done,
    output logic done_nack,
    output logic [7:0] rdata
);
    typedef enum logic [2:0] {HS_IDLE, HS_WAIT, HS_START, HS_BYTE, HS_STOP} rsi_hst_t;

    rsi_hst_t st_q;
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [15:0] qcnt_q;
    logic [15:0] idle_q;
    logic [1:0] q_q;
    logic [3:0] bcnt_q;
    logic [1:0] step_q;
    logic [7:0] txs_q;
    logic [7:0] rxs_q;
    logic ack_q;
    logic id_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic [7:0] data_q;
    logic err_q;
    logic retry_q;
    logic [7:0] tries_q;
    logic scl_q;
    logic sda_q;
    logic ready_q;
    logic done_q;
    logic nack_q;
    logic [7:0] rdata_q;

    wire scl_s = scl_s_q[1];
    wire sda_s = sda_s_q[1];
    wire sym_act = (st_q == HS_START) | (st_q == HS_BYTE) | (st_q == HS_STOP);
    wire tick = qcnt_q == 16'(QTR_CYC - 1);
    wire sym_end = tick & (q_q == 2'd3);
    wire [6:0] code_w = id_q ? RSI_CODE_ID : RSI_CODE_RTC;
    wire [7:0] first_w = {code_w, step_q != 2'd0}; // R9
    wire rx_w = rd_q & (step_q == 2'd3);
    wire bit_w = (!rx_w && bcnt_q < 4'd8) ? txs_q[7] : 1'b1; // R6 R8 R13
    wire hold_w = time_wr_hold & ~cmd_read & ~cmd_id & (cmd_addr <= RSI_TIME_LAST); // R22
    wire take_w = cmd_valid & ready_q & ~hold_w;
    wire scl_w = (st_q == HS_START) ? (q_q == 2'd1 || q_q == 2'd2) :
                 (st_q == HS_BYTE) ? (q_q == 2'd1 || q_q == 2'd2) : // R4
                 (st_q == HS_STOP) ? (q_q != 2'd0) : 1'b1;
    wire sda_w = (st_q == HS_START) ? (q_q < 2'd2) : // R1
                 (st_q == HS_BYTE) ? bit_w : // R3
                 (st_q == HS_STOP) ? (q_q >= 2'd2) : 1'b1; // R2

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.scl};
            sda_s_q <= {sda_s_q[0], bus.sda};
            scl_q <= scl_w;
            sda_q <= sda_w;
        end
    end

    // quarter-period divider for the serial clock
    always_ff @(posedge clock) begin
        if (rst || !sym_act) begin
            qcnt_q <= 16'h0000;
            q_q <= 2'd0;
        end else if (tick) begin
            qcnt_q <= 16'h0000;
            q_q <= 2'(q_q + 2'd1);
        end else begin
            qcnt_q <= 16'(qcnt_q + 16'h0001);
        end
    end

    // sample while scl high
    always_ff @(posedge clock) begin
        if (rst) begin
            rxs_q <= 8'h00;
            ack_q <= 1'b0;
        end else if (st_q == HS_BYTE && tick && q_q == 2'd1) begin
            if (bcnt_q < 4'd8) begin
                rxs_q <= {rxs_q[6:0], sda_s};
            end else begin
                ack_q <= ~sda_s; // R7
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= HS_IDLE;
            idle_q <= 16'h0000;
            bcnt_q <= 4'h0;
            step_q <= 2'd0;
            txs_q <= 8'h00;
            id_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            data_q <= 8'h00;
            err_q <= 1'b0;
            retry_q <= 1'b0;
            tries_q <= 8'h00;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                HS_IDLE: begin
                    ready_q <= ~take_w;
                    if (take_w) begin
                        id_q <= cmd_id;
                        rd_q <= cmd_read;
                        addr_q <= cmd_addr;
                        data_q <= cmd_wdata;
                        err_q <= 1'b0;
                        retry_q <= 1'b0;
                        tries_q <= 8'h00;
                        step_q <= 2'd0;
                        idle_q <= 16'h0000;
                        st_q <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (!(scl_s && sda_s)) begin
                        idle_q <= 16'h0000; // R5
                    end else if (idle_q == 16'(RSI_BUS_IDLE_CYC - 1)) begin
                        st_q <= HS_START; // R5
                    end else begin
                        idle_q <= 16'(idle_q + 16'h0001);
                    end
                end
                HS_START: begin
                    if (sym_end) begin
                        st_q <= HS_BYTE;
                        bcnt_q <= 4'h0;
                        txs_q <= first_w;
                    end
                end
                HS_BYTE: begin
                    if (sym_end && bcnt_q < 4'd8) begin
                        bcnt_q <= 4'(bcnt_q + 4'h1);
                        txs_q <= {txs_q[6:0], 1'b0};
                    end else if (sym_end) begin
                        bcnt_q <= 4'h0;
                        unique case (step_q)
                            2'd0: begin
                                if (ack_q) begin
                                    step_q <= 2'd1;
                                    txs_q <= addr_q; // R13
                                end else begin
                                    st_q <= HS_STOP;
                                    retry_q <= 1'b1; // R16
                                end
                            end
                            2'd1: begin
                                step_q <= 2'd2;
                                txs_q <= data_q;
                                if (!ack_q) begin
                                    st_q <= HS_STOP;
                                    err_q <= 1'b1;
                                end else if (rd_q) begin
                                    st_q <= HS_START;
                                end
                            end
                            2'd2: begin
                                if (rd_q && ack_q) begin
                                    step_q <= 2'd3;
                                end else begin
                                    st_q <= HS_STOP;
                                    err_q <= ~ack_q;
                                end
                            end
                            2'd3: begin
                                st_q <= HS_STOP; // R8
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (sym_end && retry_q && tries_q != POLL_MAX) begin
                        tries_q <= 8'(tries_q + 8'h01);
                        retry_q <= 1'b0;
                        step_q <= 2'd0;
                        idle_q <= 16'h0000;
                        st_q <= HS_WAIT; // R16
                    end else if (sym_end) begin
                        st_q <= HS_IDLE;
                        done_q <= 1'b1;
                        nack_q <= err_q | retry_q;
                        rdata_q <= rxs_q;
                    end
                end
            endcase
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe_n = scl_q;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = sda_q;
    assign cmd_ready = ready_q;
    assign done = done_q;
    assign done_nack = nack_q;
    assign rdata = rdata_q;
endmodule

// [dv/rsi_sva.sv]
`timescale 1ns/1ps
module rsi_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_scl_o,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_o,
    input wire logic s_sda_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_low_only: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
        else $error("line driven high");
    a_dev_sda_low: assert property ($changed(s_sda_oe_n) |-> !scl)
        else $error("device sda moved in scl high");
    a_mst_sda_cond: assert property ($changed(m_sda_oe_n) && scl |-> $past(scl, 20))
        else $error("master sda moved early in scl high");
    a_start_setup: assert property ($fell(sda) && scl |-> $past(scl, 20) && $past(sda, 20))
        else $error("bad start");
    a_stop_setup: assert property ($rose(sda) && scl |-> $past(scl, 20) && !$past(sda, 20))
        else $error("bad stop");
    a_bit_stable: assert property ($rose(scl) |-> (scl && $stable(sda))[*8])
        else $error("bit unstable");
    a_ack_held: assert property ($rose(scl) && !s_sda_oe_n |-> ##50 (scl && !sda))
        else $error("ack not held");
    a_ack_free: assert property (!s_sda_oe_n && scl |-> m_sda_oe_n)
        else $error("master drives over device");
    cover property ($fell(s_sda_oe_n));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb
    import rsi_pkg::*;
;
    logic clock, rst, link_clk, cmd_valid, cmd_ready, cmd_id, cmd_read, time_wr_hold;
    logic done, done_nack, wr_pulse, id_busy;
    logic [7:0] cmd_addr, cmd_wdata, rdata, wr_addr, wr_data, got_a, got_d;
    rsi_region_t wr_region, got_r;
    int errors, n_tests, n_wr, m;
    logic [7:0] bnd [5] = '{8'h09, 8'h0a, 8'h17, 8'h18, 8'h20};
    rsi_if bus_if();
    rsi_host #(.QTR_CYC(30), .POLL_MAX(8'h14)) u_rsi_host (.clock(clock), .rst(rst),
        .bus(bus_if.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .time_wr_hold(time_wr_hold), .done(done), .done_nack(done_nack), .rdata(rdata));
    rsi_device #(.WC_CYCLES(3000)) u_rsi_device (.clock(clock), .rst(rst),
        .link_clk(link_clk), .bus(bus_if.slave), .wr_pulse(wr_pulse), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_region(wr_region), .id_busy(id_busy));
    rsi_sva u_rsi_sva (.clock(clock), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
        .m_scl_o(bus_if.m_scl_o), .m_sda_o(bus_if.m_sda_o), .m_sda_oe_n(bus_if.m_sda_oe_n),
        .s_sda_o(bus_if.s_sda_o), .s_sda_oe_n(bus_if.s_sda_oe_n));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #6 link_clk = ~link_clk;
    end
    always @(negedge clock) begin
        if (wr_pulse === 1'b1) begin
            n_wr++;
            got_a = wr_addr;
            got_d = wr_data;
            got_r = wr_region;
        end
    end
    function automatic rsi_region_t region_of(input logic [7:0] a);
        if (a <= 8'h06) return RSI_RG_TIME;
        if (a <= 8'h09) return RSI_RG_CFG;
        if (a <= 8'h10) return RSI_RG_ALM0;
        if (a <= 8'h17) return RSI_RG_ALM1;
        if (a <= 8'h1f) return RSI_RG_TSTAMP;
        return RSI_RG_SRAM;
    endfunction
    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one command: offer, wait for take, wait for done
    task automatic op(input logic id, input logic rd, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_id <= id;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_wdata <= d;
        do begin
            @(negedge clock);
            n++;
        end while ((cmd_ready !== 1'b1 || time_wr_hold !== 1'b0) && n < 20000);
        @(posedge clock);
        cmd_valid <= 1'b0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 20000);
        if (n >= 20000) errors++;
    endtask
    initial begin
        repeat (95000) @(posedge clock);
        errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        {cmd_valid, cmd_id, cmd_read, time_wr_hold} = 4'h0;
        {cmd_addr, cmd_wdata} = 16'h0000;
        errors = 0;
        n_tests = 0;
        n_wr = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        op(1'b0, 1'b1, 8'h07, 8'h00);
        `CHK("rst07", 8'h80, rdata)
        op(1'b0, 1'b0, 8'h00, 8'h99);
        `CHK("wnak", 1'b0, done_nack)
        `CHK("waddr", 8'h00, got_a)
        `CHK("wdata", 8'h99, got_d)
        op(1'b0, 1'b1, 8'h00, 8'h00);
        `CHK("rback", 8'h99, rdata)
        foreach (bnd[i]) begin
            op(1'b0, 1'b0, bnd[i], bnd[i] ^ 8'h3c);
            `CHK("region", region_of(bnd[i]), got_r)
            `CHK("baddr", bnd[i], got_a)
        end
        m = n_wr;
        op(1'b0, 1'b0, 8'h60, 8'h11);
        `CHK("oor", 1'b1, done_nack)
        `CHK("nstore", m, n_wr)
        @(posedge clock);
        time_wr_hold <= 1'b1;
        fork
            op(1'b0, 1'b0, 8'h02, 8'h59);
        join_none
        repeat (400) @(negedge clock);
        `CHK("held", 1'b1, cmd_ready)
        @(posedge clock);
        time_wr_hold <= 1'b0;
        wait fork;
        `CHK("hold_addr", 8'h02, got_a)
        op(1'b0, 1'b0, 8'h09, 8'h55);
        op(1'b0, 1'b0, 8'h09, 8'haa);
        `CHK("idle", 1'b0, id_busy)
        op(1'b1, 1'b0, 8'h02, 8'h5a);
        `CHK("idnak", 1'b0, done_nack)
        `CHK("idreg", RSI_RG_ID, got_r)
        repeat (10) @(negedge clock);
        `CHK("busy", 1'b1, id_busy)
        op(1'b0, 1'b1, 8'h00, 8'h00);
        `CHK("rtc_busy", 8'h99, rdata)
        op(1'b1, 1'b1, 8'h02, 8'h00);
        `CHK("poll", 1'b0, done_nack)
        `CHK("idrd", 8'h5a, rdata)
        op(1'b1, 1'b1, 8'h08, 8'h00);
        `CHK("idoor", 1'b1, done_nack)
        end_of_test();
    end
endmodule
